// *** inc/soe_regs.svh ***
`ifndef SOE_REGS_SVH
`define SOE_REGS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SOE_SHIFT_W 11
`define SOE_PAIRS 10
`define SOE_PIN_W 5
`define SOE_CNT_W 4

// ----------------------------------------
// field positions of the control word
// ----------------------------------------
`define SOE_CTRL_SRC_BIT 10
`define SOE_CTRL_GATE_MSB 9
`define SOE_CTRL_GATE_LSB 0

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define SOE_CTRL_RESET 11'h000
`define SOE_SHIFT_RESET 11'h000
`define SOE_PIN_RESET 5'h10
`define SOE_CNT_RESET 4'h0
`define SOE_FILL_PULSES 4'hb
`define SOE_ALL_GATES_ON 10'h3ff
`define SOE_ALL_GATES_OFF 10'h000

`endif

// *** inc/soe_pkg.sv ***
package soe_pkg;

	// ----------------------------------------
	// configuration state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		soe_st_empty = 3'h1,
		soe_st_fill = 3'h2,
		soe_st_loaded = 3'h4
	} soe_state_e;

	// ----------------------------------------
	// pin group and control word
	// ----------------------------------------
	typedef struct packed {
		logic shift_clock;
		logic serial_data;
		logic mode;
		logic clock_source_a;
		logic clock_source_b;
	} soe_pins_s;

	typedef struct packed {
		logic src_sel;
		logic [9:0] gate;
	} soe_ctrl_s;

endpackage

// *** rtl/soe_sync.sv ***
`timescale 1ns/1ps
`include "soe_regs.svh"

module soe_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire soe_pkg::soe_pins_s pin_async,
	output soe_pkg::soe_pins_s pin_sync
);
	import soe_pkg::*;

	logic [`SOE_PIN_W-1:0] s1_ff;
	logic [`SOE_PIN_W-1:0] s2_ff;
	logic [`SOE_PIN_W-1:0] s3_ff;
	logic [`SOE_PIN_W-1:0] out_ff;
	logic [`SOE_PIN_W-1:0] nxt_out;

	// ----------------------------------------
	// accept a level once stages two and three agree
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < `SOE_PIN_W; i++) begin
			nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s1_ff <= `SOE_PIN_RESET;
			s2_ff <= `SOE_PIN_RESET;
			s3_ff <= `SOE_PIN_RESET;
			out_ff <= `SOE_PIN_RESET;
		end else begin
			s1_ff <= pin_async;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign pin_sync = out_ff;

endmodule

// *** rtl/soe_shift.sv ***
`timescale 1ns/1ps
`include "soe_regs.svh"

module soe_shift (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic shift,
	input wire logic din,
	output logic [`SOE_SHIFT_W-1:0] q
);
	import soe_pkg::*;

	logic [`SOE_SHIFT_W-1:0] sh_ff;
	logic [`SOE_SHIFT_W-1:0] nxt_sh;

	// ----------------------------------------
	// serial-in shift chain
	// ----------------------------------------
	always_comb begin
		nxt_sh = sh_ff;
		if (clear) begin
			nxt_sh = `SOE_SHIFT_RESET;
		end else if (shift) begin
			nxt_sh = {sh_ff[`SOE_SHIFT_W-2:0], din};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sh_ff <= `SOE_SHIFT_RESET;
		end else begin
			sh_ff <= nxt_sh;
		end
	end

	assign q = sh_ff;

endmodule

// *** rtl/soe_top.sv ***
`timescale 1ns/1ps
`include "soe_regs.svh"

module soe_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic shift_clock,
	input wire logic serial_data,
	input wire logic mode,
	input wire logic clock_source_a,
	input wire logic clock_source_b,
	output logic [9:0] fanout_output_pair,
	output logic [9:0] fanout_output_oe,
	output logic source_b_selected,
	output logic config_loaded
);
	import soe_pkg::*;

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	soe_pins_s pin_raw;
	soe_pins_s pin_s;

	assign pin_raw.shift_clock = shift_clock;
	assign pin_raw.serial_data = serial_data;
	assign pin_raw.mode = mode;
	assign pin_raw.clock_source_a = clock_source_a;
	assign pin_raw.clock_source_b = clock_source_b;

	soe_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pin_async(pin_raw),
		.pin_sync(pin_s)
	);

	// ----------------------------------------
	// shift clock edge detection
	// ----------------------------------------
	logic sck_prev_ff;
	logic nxt_sck_prev;
	logic sck_rise;
	logic restart;
	logic prog_pulse;

	always_comb begin
		nxt_sck_prev = pin_s.shift_clock;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sck_prev_ff <= 1'h1;
		end else begin
			sck_prev_ff <= nxt_sck_prev;
		end
	end

	assign sck_rise = pin_s.shift_clock & ~sck_prev_ff;
	assign restart = sck_rise & ~pin_s.mode;
	assign prog_pulse = sck_rise & pin_s.mode;

	// ----------------------------------------
	// configuration state machine
	// ----------------------------------------
	soe_state_e state_ff;
	soe_state_e nxt_state;
	logic [`SOE_CNT_W-1:0] cnt_ff;
	logic [`SOE_CNT_W-1:0] nxt_cnt;
	soe_ctrl_s ctrl_ff;
	soe_ctrl_s nxt_ctrl;
	logic do_shift;
	logic [`SOE_SHIFT_W-1:0] sh_q;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_ctrl = ctrl_ff;
		do_shift = 1'h0;
		if (restart) begin
			nxt_state = soe_st_empty;
			nxt_cnt = `SOE_CNT_RESET;
			nxt_ctrl = `SOE_CTRL_RESET;
		end else if (prog_pulse) begin
			unique case (state_ff)
				soe_st_empty, soe_st_fill: begin
					if (cnt_ff < `SOE_FILL_PULSES) begin
						do_shift = 1'h1;
						nxt_cnt = cnt_ff + `SOE_CNT_W'(1);
						nxt_state = soe_st_fill;
					end else begin
						// shift chain holds bit 10 at stage 0, bit 9 at stage 10, bit 0 at stage 1
						nxt_ctrl.src_sel = sh_q[0];
						nxt_ctrl.gate = sh_q[`SOE_SHIFT_W-1:1];
						nxt_state = soe_st_loaded;
					end
				end
				soe_st_loaded: begin
					nxt_state = soe_st_loaded;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_ff <= soe_st_empty;
			cnt_ff <= `SOE_CNT_RESET;
			ctrl_ff <= `SOE_CTRL_RESET;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ctrl_ff <= nxt_ctrl;
		end
	end

	soe_shift u_shift (
		.clk(clk),
		.rst_b(rst_b),
		.clear(restart),
		.shift(do_shift),
		.din(pin_s.serial_data),
		.q(sh_q)
	);

	// ----------------------------------------
	// source selector and output gating
	// ----------------------------------------
	logic [9:0] pair_ff;
	logic [9:0] nxt_pair;
	logic [9:0] oe_ff;
	logic [9:0] nxt_oe;
	logic srcb_ff;
	logic nxt_srcb;
	logic loaded_ff;
	logic nxt_loaded;
	logic clk_sel;

	always_comb begin
		if (pin_s.mode) begin
			nxt_srcb = ctrl_ff.src_sel;
			nxt_oe = ctrl_ff.gate;
		end else begin
			nxt_srcb = pin_s.serial_data;
			nxt_oe = `SOE_ALL_GATES_ON;
		end
		clk_sel = nxt_srcb ? pin_s.clock_source_b : pin_s.clock_source_a;
		nxt_pair = {`SOE_PAIRS{clk_sel}} & nxt_oe;
		nxt_loaded = (state_ff == soe_st_loaded);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pair_ff <= `SOE_ALL_GATES_OFF;
			oe_ff <= `SOE_ALL_GATES_OFF;
			srcb_ff <= 1'h0;
			loaded_ff <= 1'h0;
		end else begin
			pair_ff <= nxt_pair;
			oe_ff <= nxt_oe;
			srcb_ff <= nxt_srcb;
			loaded_ff <= nxt_loaded;
		end
	end

	assign fanout_output_pair = pair_ff;
	assign fanout_output_oe = oe_ff;
	assign source_b_selected = srcb_ff;
	assign config_loaded = loaded_ff;

endmodule

// *** verification/soe_monitor.sv ***
`timescale 1ns/1ps
module soe_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic serial_data,
	input wire logic mode,
	input wire logic [9:0] fanout_output_pair,
	input wire logic [9:0] fanout_output_oe,
	input wire logic source_b_selected,
	input wire logic config_loaded
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	reset_clear_a: assert property ($rose(rst_b) |-> !fanout_output_oe && !config_loaded && !source_b_selected)
		else $error("not cleared by reset");
	pair_gated_a: assert property ((fanout_output_pair & ~fanout_output_oe) == 10'h000)
		else $error("floated pair driven");
	loaded_sticky_a: assert property ((mode && config_loaded) [*8] |=> config_loaded)
		else $error("load lost");
	std_all_on_a: assert property ((!mode) [*8] |-> fanout_output_oe == 10'h3ff)
		else $error("standard mode gating");
	std_src_b_a: assert property ((!mode && serial_data) [*8] |-> source_b_selected)
		else $error("source b not picked");
	std_src_a_a: assert property ((!mode && !serial_data) [*8] |-> !source_b_selected)
		else $error("source a not picked");
	load_mode_a: assert property ($rose(config_loaded) |-> mode && $past(mode, 8))
		else $error("load outside programmable mode");
	prog_empty_a: assert property ((mode && !config_loaded) [*8] |-> fanout_output_oe == 10'h000)
		else $error("gating before load");
endmodule

bind soe_top soe_monitor u_mon (.clk(clk), .rst_b(rst_b), .serial_data(serial_data), .mode(mode),
	.fanout_output_pair(fanout_output_pair), .fanout_output_oe(fanout_output_oe),
	.source_b_selected(source_b_selected), .config_loaded(config_loaded));

// *** verification/soe_ctl_model.sv ***
`timescale 1ns/1ps
module soe_ctl_model (
	input wire logic clk,
	output logic shift_clock = 1'b1,
	output logic serial_data = 1'b0,
	output logic mode = 1'b0
);
	// data changes while clock low, driven back to 0 after hold
	task automatic pulse(input logic d);
		@(negedge clk);
		shift_clock = 1'b0;
		serial_data = d;
		#62.5;
		shift_clock = 1'b1;
		#62.5;
		serial_data = 1'b0;
	endtask
	task automatic shift_word(input logic [11:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			pulse(w[i]);
		end
	endtask
	task automatic set_pins(input logic m, input logic d);
		@(negedge clk);
		mode = m;
		serial_data = d;
	endtask
	task automatic restart();
		set_pins(1'b0, 1'b0);
		pulse(1'b0);
		set_pins(1'b1, 1'b0);
	endtask
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sa = 1'b1;
	logic sb = 1'b0;
	logic sck;
	logic sd;
	logic md;
	logic srcb;
	logic ld;
	logic [9:0] pair;
	logic [9:0] oe;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	initial begin
		forever #4 clk = ~clk;
	end
	soe_ctl_model ctl (.clk(clk), .shift_clock(sck), .serial_data(sd), .mode(md));
	soe_top DUT (.clk(clk), .rst_b(rst_b), .shift_clock(sck), .serial_data(sd), .mode(md),
		.clock_source_a(sa), .clock_source_b(sb), .fanout_output_pair(pair), .fanout_output_oe(oe),
		.source_b_selected(srcb), .config_loaded(ld));
	task automatic tally_and_finish();
		if (err_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			tally_and_finish();
		end
	end
	function automatic logic [21:0] e(input logic l, input logic s, input logic [9:0] g);
		return {l, s, g, g & {10{s ? sb : sa}}};
	endfunction
	function automatic logic [9:0] gates(input logic [11:0] w);
		for (int i = 0; i < 10; i++) begin
			gates[9 - i] = w[i];
		end
	endfunction
	task automatic chk(input logic [21:0] x);
		repeat (12) @(negedge clk);
		num_checks++;
		if ({ld, srcb, oe, pair} !== x) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, {ld, srcb, oe, pair}, x);
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		chk(e(1'b0, 1'b0, 10'h3ff));
		ctl.set_pins(1'b0, 1'b1);
		chk(e(1'b0, 1'b1, 10'h3ff));
		ctl.set_pins(1'b1, 1'b0);
		chk(e(1'b0, 1'b0, 10'h000));
		sb = 1'b1;
		ctl.shift_word(12'h4a5, 12);
		chk(e(1'b1, 1'b1, gates(12'h4a5)));
		ctl.shift_word(12'h35a, 12);
		chk(e(1'b1, 1'b1, gates(12'h4a5)));
		ctl.set_pins(1'b0, 1'b0);
		chk(e(1'b1, 1'b0, 10'h3ff));
		ctl.set_pins(1'b1, 1'b0);
		chk(e(1'b1, 1'b1, gates(12'h4a5)));
		ctl.restart();
		ctl.shift_word(12'h7ff, 11);
		chk(e(1'b0, 1'b0, 10'h000));
		ctl.pulse(1'b0);
		chk(e(1'b1, 1'b1, 10'h3ff));
		ctl.restart();
		ctl.shift_word(12'h35a, 12);
		chk(e(1'b1, 1'b0, gates(12'h35a)));
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		chk(e(1'b0, 1'b0, 10'h000));
		tally_and_finish();
	end
endmodule
